// File: logic/qprb_defines.svh
`ifndef QPRB_DEFINES_SVH
`define QPRB_DEFINES_SVH

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define QPRB_AW          9
`define QPRB_NREG        16
`define QPRB_NPEND       6
`define QPRB_NQUEUE      96
`define QPRB_HALF        16

// ---------------------------------------------------------------
// Byte offsets on the register bus
// ---------------------------------------------------------------
`define QPRB_OFS_LINK_LO  9'h000
`define QPRB_OFS_LINK_HI  9'h004
`define QPRB_OFS_IRQ_STAT 9'h008
`define QPRB_OFS_IRQ_MASK 9'h00c
// Pending words live at 0x040 + 4*i, i = 0..5
`define QPRB_PEND_PAGE    4'h2
`define QPRB_PEND_PG_MSB  8
`define QPRB_PEND_PG_LSB  5
`define QPRB_PIDX_MSB     4
`define QPRB_PIDX_LSB     2
// Region R registers live at 0x100 + 0x10*R + 4*sel
`define QPRB_REGION_BIT   8
`define QPRB_RIDX_MSB     7
`define QPRB_RIDX_LSB     4
`define QPRB_SEL_MSB      3
`define QPRB_SEL_LSB      2
`define QPRB_SEL_BASE_LO  2'h0
`define QPRB_SEL_BASE_HI  2'h1
`define QPRB_SEL_CFG_A    2'h2
`define QPRB_SEL_CFG_B    2'h3

// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define QPRB_DSZ_MSB      11
`define QPRB_DSZ_LSB      8
`define QPRB_RSZ_MSB      2
`define QPRB_RSZ_LSB      0
`define QPRB_SIDX_MSB     13
`define QPRB_DSZ_MAX      4'h8
`define QPRB_MIN_UNIT     14'h0020
`define QPRB_FULL_HALF_BE 2'h3

// ---------------------------------------------------------------
// Interrupt layout and reset values
// ---------------------------------------------------------------
`define QPRB_IRQ_W        7
`define QPRB_IRQ_BADSZ    6
`define QPRB_RST_HALF     16'h0000
`define QPRB_RST_IRQ      7'h00
`define QPRB_RST_DSZ      4'h0
`define QPRB_RST_RSZ      3'h0
`define QPRB_RST_SIDX     14'h0000

`endif

// File: logic/qprb_pkg.sv
package qprb_pkg;
`include "qprb_defines.svh"

	typedef logic [`QPRB_HALF-1:0]    qprb_half_t;
	typedef logic [31:0]              qprb_word_t;
	typedef logic [`QPRB_AW-1:0]      qprb_addr_t;
	typedef logic [3:0]               qprb_dsz_t;
	typedef logic [2:0]               qprb_rsz_t;
	typedef logic [`QPRB_SIDX_MSB:0]  qprb_sidx_t;
	typedef logic [13:0]              qprb_size_t;
	typedef logic [`QPRB_IRQ_W-1:0]   qprb_irq_t;

	// Power-of-two size from a code: 32 << code
	function automatic qprb_size_t qprb_pow32(input logic [3:0] code);
		qprb_size_t v;
		v = `QPRB_MIN_UNIT << code;
		return v;
	endfunction

endpackage

// File: logic/qprb_region_decode.sv
`timescale 1ns/100ps
module qprb_region_decode
	import qprb_pkg::*;
(
	input  wire qprb_dsz_t descSizeCode,
	input  wire qprb_rsz_t regSizeCode,
	output qprb_size_t  descBytes,
	output logic [12:0] descCount,
	output logic        sizeValid
);
	wire         dszLegal;
	wire [13:0]  countWide;

	// ---------------------------------------------------------------
	// Descriptor size and region count
	// ---------------------------------------------------------------
	// descriptor size decode
	assign dszLegal  = (descSizeCode <= `QPRB_DSZ_MAX);
	// Reserved codes report zero rather than wrapping the shift
	assign descBytes = dszLegal ? qprb_pow32(descSizeCode) : '0;
	assign sizeValid = dszLegal;
	assign countWide = qprb_pow32({1'b0, regSizeCode});
	assign descCount = countWide[12:0];
endmodule

// File: logic/qprb_regs.sv
// Function
// - hold upper 16 bits of second linking-memory region base, read/write.
// - six read-only pending words, sixteen queues each, queues 0 to 95.
// - host programs sixteen region base addresses; each is retained.
// - each region holds equal descriptors, count and size from its config.
// - region base is low and high 16-bit halves forming 32 bits.
// - host writes two config registers per region; both stored per region.
// - descriptor size code 0..8 gives 32 to 8K bytes; 9..F reserved.
// - region size code 0..7 gives 32 to 4K descriptors.
// - 14-bit start index per region in second config register.
// - lower 16 bits of second linking region base held separately.
//
// The implementer's own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/100ps
module qprb_regs
	import qprb_pkg::*;
(
	input  wire logic                        ref_clk,
	input  wire logic                        rstn,
	input  wire qprb_addr_t                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire qprb_word_t                  avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output qprb_word_t                       avs_readdata,
	output logic                             avs_waitrequest,
	input  wire logic [`QPRB_NQUEUE-1:0]     pendingIn,
	output logic                             irq,
	output qprb_word_t                       linkRegion1Base,
	output logic [`QPRB_NREG-1:0][31:0]      regionBase,
	output logic [`QPRB_NREG-1:0][13:0]      regionDescBytes,
	output logic [`QPRB_NREG-1:0][12:0]      regionDescCount,
	output logic [`QPRB_NREG-1:0]            regionSizeValid,
	output logic [`QPRB_NREG-1:0][13:0]      regionStartIndex,
	output logic [`QPRB_NREG-1:0]            regionCfgUpdate
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	qprb_half_t                    linkLoQ;
	qprb_half_t                    linkHiQ;
	qprb_half_t                    baseLoQ  [`QPRB_NREG];
	qprb_half_t                    baseHiQ  [`QPRB_NREG];
	// Reserved size codes are kept as written so software reads them back
	qprb_dsz_t                     dszQ     [`QPRB_NREG];
	qprb_rsz_t                     rszQ     [`QPRB_NREG];
	qprb_sidx_t                    sidxQ    [`QPRB_NREG];
	logic [`QPRB_NQUEUE-1:0]       pendQ;
	qprb_irq_t                     irqStatQ;
	qprb_irq_t                     irqStatD;
	qprb_irq_t                     irqMaskQ;
	logic                          ackQ;
	qprb_word_t                    rdataQ;
	logic [`QPRB_NREG-1:0]         cfgUpdQ;

	// ---------------------------------------------------------------
	// Bus handshake
	// ---------------------------------------------------------------
	// One wait state: the request is latched, then answered
	// Fixed latency keeps the decode off the request path; a master
	// must still wait on waitrequest rather than count cycles
	wire        busReq;
	wire        accept;
	wire        fullHalf;
	wire        wrEn;

	assign busReq          = avs_read | avs_write;
	assign accept          = busReq & ~ackQ;
	assign avs_waitrequest = busReq & ~ackQ;
	assign avs_readdata    = rdataQ;
	assign fullHalf = (avs_byteenable[1:0] == `QPRB_FULL_HALF_BE);
	assign wrEn     = avs_write & ackQ & fullHalf;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ackQ <= 1'b0;
		end else begin
			ackQ <= accept;
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	wire        regionHit;
	wire [3:0]  regIdx;
	wire [1:0]  regSel;
	wire        pendHit;
	wire [2:0]  pendIdx;
	wire        linkLoHit;
	wire        linkHiHit;
	wire        statHit;
	wire        maskHit;

	assign regionHit = avs_address[`QPRB_REGION_BIT];
	assign regIdx    = avs_address[`QPRB_RIDX_MSB:`QPRB_RIDX_LSB];
	assign regSel    = avs_address[`QPRB_SEL_MSB:`QPRB_SEL_LSB];
	assign pendIdx   = avs_address[`QPRB_PIDX_MSB:`QPRB_PIDX_LSB];
	assign pendHit   = (avs_address[`QPRB_PEND_PG_MSB:`QPRB_PEND_PG_LSB]
		== `QPRB_PEND_PAGE) && (pendIdx < 3'(`QPRB_NPEND));
	assign linkLoHit = (avs_address == `QPRB_OFS_LINK_LO);
	assign linkHiHit = (avs_address == `QPRB_OFS_LINK_HI);
	assign statHit   = (avs_address == `QPRB_OFS_IRQ_STAT);
	assign maskHit   = (avs_address == `QPRB_OFS_IRQ_MASK);

	// ---------------------------------------------------------------
	// Second linking region base
	// ---------------------------------------------------------------
	wire        wrLinkLo;
	wire        wrLinkHi;

	assign wrLinkLo = wrEn & linkLoHit;
	assign wrLinkHi = wrEn & linkHiHit;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			linkLoQ <= `QPRB_RST_HALF;
			linkHiQ <= `QPRB_RST_HALF;
		end else begin
			if (wrLinkLo) begin
				linkLoQ <= avs_writedata[15:0];
			end
			if (wrLinkHi) begin
				linkHiQ <= avs_writedata[15:0];
			end
		end
	end

	assign linkRegion1Base = {linkHiQ, linkLoQ};

	// ---------------------------------------------------------------
	// Descriptor memory regions
	// ---------------------------------------------------------------
	wire [`QPRB_NREG-1:0] badSizeWr;

	genvar r;
	generate
		for (r = 0; r < `QPRB_NREG; r++) begin : g_region
			wire rHit;
			wire wrBaseLo;
			wire wrBaseHi;
			wire wrCfgA;
			wire wrCfgB;
			wire [3:0] newDsz;

			assign rHit     = wrEn & regionHit & (regIdx == 4'(r));
			assign wrBaseLo = rHit & (regSel == `QPRB_SEL_BASE_LO);
			assign wrBaseHi = rHit & (regSel == `QPRB_SEL_BASE_HI);
			assign wrCfgA   = rHit & (regSel == `QPRB_SEL_CFG_A);
			assign wrCfgB   = rHit & (regSel == `QPRB_SEL_CFG_B);
			assign newDsz   =
				avs_writedata[`QPRB_DSZ_MSB:`QPRB_DSZ_LSB];
			assign badSizeWr[r] = wrCfgA & (newDsz > `QPRB_DSZ_MAX);

			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					baseLoQ[r] <= `QPRB_RST_HALF;
					baseHiQ[r] <= `QPRB_RST_HALF;
					dszQ[r]    <= `QPRB_RST_DSZ;
					rszQ[r]    <= `QPRB_RST_RSZ;
					sidxQ[r]   <= `QPRB_RST_SIDX;
					cfgUpdQ[r] <= 1'b0;
				end else begin
					if (wrBaseLo) begin
						baseLoQ[r] <= avs_writedata[15:0];
					end
					if (wrBaseHi) begin
						baseHiQ[r] <= avs_writedata[15:0];
					end
					if (wrCfgA) begin
						dszQ[r] <= newDsz;
						rszQ[r] <=
							avs_writedata[`QPRB_RSZ_MSB:`QPRB_RSZ_LSB];
					end
					if (wrCfgB) begin
						sidxQ[r] <= avs_writedata[`QPRB_SIDX_MSB:0];
					end
					// Pulse lets the engine reload this region's settings
					cfgUpdQ[r] <= rHit;
				end
			end

			assign regionBase[r]       = {baseHiQ[r], baseLoQ[r]};
			assign regionStartIndex[r] = sidxQ[r];

			// Decoded sizes stay combinational and follow the stored codes
			// equal descriptors per region
			qprb_region_decode u_decode (
				.descSizeCode (dszQ[r]),
				.regSizeCode  (rszQ[r]),
				.descBytes    (regionDescBytes[r]),
				.descCount    (regionDescCount[r]),
				.sizeValid    (regionSizeValid[r])
			);
		end
	endgenerate

	assign regionCfgUpdate = cfgUpdQ;

	// ---------------------------------------------------------------
	// Queue pending status
	// ---------------------------------------------------------------
	// Sampled copy keeps read data and the rise detector consistent
	wire [`QPRB_NPEND-1:0] pendRise;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pendQ <= '0;
		end else begin
			pendQ <= pendingIn;
		end
	end

	genvar p;
	generate
		for (p = 0; p < `QPRB_NPEND; p++) begin : g_pend
			assign pendRise[p] =
				|(pendingIn[p*`QPRB_HALF +: `QPRB_HALF]
				& ~pendQ[p*`QPRB_HALF +: `QPRB_HALF]);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Interrupts
	// ---------------------------------------------------------------
	wire        wrStat;
	wire        wrMask;
	qprb_irq_t  irqEvent;
	qprb_irq_t  irqClear;

	assign wrStat   = wrEn & statHit;
	assign wrMask   = wrEn & maskHit;
	// Bit 6 flags a reserved descriptor size written to any region
	assign irqEvent = {|badSizeWr, pendRise};
	assign irqClear = wrStat ? avs_writedata[`QPRB_IRQ_W-1:0] : '0;
	// A new event beats a simultaneous write-one-to-clear
	assign irqStatD = (irqStatQ & ~irqClear) | irqEvent;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			irqStatQ <= `QPRB_RST_IRQ;
			irqMaskQ <= `QPRB_RST_IRQ;
		end else begin
			irqStatQ <= irqStatD;
			if (wrMask) begin
				irqMaskQ <= avs_writedata[`QPRB_IRQ_W-1:0];
			end
		end
	end

	// Mask shares the status layout bit for bit
	assign irq = |(irqStatQ & irqMaskQ);

	// ---------------------------------------------------------------
	// Read data
	// ---------------------------------------------------------------
	// Reserved bits return zero; unmapped addresses read as zero
	qprb_half_t regionRd;
	qprb_half_t cfgARd;
	qprb_half_t cfgBRd;
	qprb_half_t pendRd;
	qprb_half_t rdHalf;
	qprb_word_t rdataD;

	assign cfgARd = {4'h0, dszQ[regIdx], 5'h00, rszQ[regIdx]};
	assign cfgBRd = {2'h0, sidxQ[regIdx]};
	assign regionRd =
		(regSel == `QPRB_SEL_BASE_LO) ? baseLoQ[regIdx] :
		(regSel == `QPRB_SEL_BASE_HI) ? baseHiQ[regIdx] :
		(regSel == `QPRB_SEL_CFG_A)   ? cfgARd : cfgBRd;
	// Indices 6 and 7 of the pending page fall through to zero
	// pending word readback
	assign pendRd = pendHit ?
		pendQ[pendIdx*`QPRB_HALF +: `QPRB_HALF] : `QPRB_RST_HALF;
	assign rdHalf =
		regionHit ? regionRd :
		pendHit   ? pendRd   :
		linkLoHit ? linkLoQ  :
		linkHiHit ? linkHiQ  :
		statHit   ? {9'h000, irqStatQ} :
		maskHit   ? {9'h000, irqMaskQ} : `QPRB_RST_HALF;
	assign rdataD = {16'h0000, rdHalf};

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdataQ <= '0;
		end else if (accept && avs_read) begin
			rdataQ <= rdataD;
		end
	end

endmodule

// File: tb/qprb_regs_assertions.sv
`timescale 1ns/100ps
module qprb_regs_assertions
	import qprb_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rstn,
	input wire qprb_addr_t        avs_address,
	input wire logic              avs_read,
	input wire logic              avs_write,
	input wire qprb_word_t        avs_writedata,
	input wire logic [3:0]        avs_byteenable,
	input wire logic              avs_waitrequest,
	input wire logic              irq,
	input wire qprb_word_t        linkRegion1Base,
	input wire logic [15:0][31:0] regionBase,
	input wire logic [15:0][13:0] regionDescBytes,
	input wire logic [15:0][12:0] regionDescCount,
	input wire logic [15:0][13:0] regionStartIndex,
	input wire logic [15:0]       regionCfgUpdate
);
	// Only a full-width write that completes may change state
	wire        wrDone = avs_write && !avs_waitrequest;
	wire        fullWr = wrDone && avs_byteenable[1:0] == 2'h3;
	wire        isReg  = avs_address[8];
	wire [1:0]  sel    = avs_address[3:2];
	wire [3:0]  rIdx   = avs_address[7:4];
	wire [15:0] wd     = avs_writedata[15:0];
	wire        regWr  = fullWr && isReg;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	a_link_high_store: assert property (
		fullWr && avs_address == 9'h004 |=>
		linkRegion1Base[31:16] == $past(wd)) else $error("link high lost");
	a_link_low_store: assert property (
		fullWr && avs_address == 9'h000 |=>
		linkRegion1Base[15:0] == $past(wd)) else $error("link low lost");
	a_base_high_store: assert property (
		regWr && sel == 2'h1 |=>
		regionBase[$past(rIdx)][31:16] == $past(wd))
		else $error("region base high lost");
	a_descriptor_byte_size_decode: assert property (
		regWr && sel == 2'h2 |=> regionDescBytes[$past(rIdx)] ==
		($past(wd[11:8]) <= 4'h8 ? 14'h20 << $past(wd[11:8]) : 14'h0))
		else $error("descriptor size decode wrong");
	a_desc_count_decode: assert property (
		regWr && sel == 2'h2 |=>
		regionDescCount[$past(rIdx)] == 13'h20 << $past(wd[2:0]))
		else $error("region count decode wrong");
	a_start_index_store: assert property (
		regWr && sel == 2'h3 |=>
		regionStartIndex[$past(rIdx)] == $past(wd[13:0]))
		else $error("start index lost");
	a_partial_write_drop: assert property (
		wrDone && avs_byteenable[1:0] != 2'h3 |=> $stable(linkRegion1Base)
		&& $stable(regionBase) && $stable(regionStartIndex))
		else $error("partial write changed state");
	a_cfg_update_pulse: assert property (
		regWr |=> regionCfgUpdate == 16'h1 << $past(rIdx)
		##1 regionCfgUpdate == 16'h0) else $error("update pulse wrong");

	c_region_write: cover property (regWr);
	c_read_done: cover property (avs_read && !avs_waitrequest);
	c_irq_rise: cover property ($rose(irq));
endmodule

bind qprb_regs qprb_regs_assertions qprb_regs_assertions_i (
	.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_waitrequest(avs_waitrequest), .irq(irq),
	.linkRegion1Base(linkRegion1Base), .regionBase(regionBase),
	.regionDescBytes(regionDescBytes), .regionDescCount(regionDescCount),
	.regionStartIndex(regionStartIndex), .regionCfgUpdate(regionCfgUpdate)
);

// File: tb/qprb_regs_tb.sv
`timescale 1ns/100ps
module qprb_regs_tb
	import qprb_pkg::*;
;
	logic              ref_clk = 1'b0;
	logic              rstn = 1'b0;
	qprb_addr_t        avs_address = 9'h000;
	logic              avs_read = 1'b0;
	logic              avs_write = 1'b0;
	qprb_word_t        avs_writedata = 32'h0;
	logic [3:0]        avs_byteenable = 4'h0;
	qprb_word_t        avs_readdata;
	logic              avs_waitrequest;
	logic [95:0]       pendingIn = 96'h0;
	logic              irq;
	qprb_word_t        linkBase;
	logic [15:0][31:0] regionBase;
	logic [15:0][13:0] descBytes;
	logic [15:0][12:0] descCount;
	logic [15:0]       sizeValid;
	logic [15:0][13:0] startIdx;
	logic [15:0]       cfgUpd;
	int                errCount = 0;
	int                samplesChecked = 0;

	qprb_regs qprb_regs_i (
		.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.pendingIn(pendingIn), .irq(irq), .linkRegion1Base(linkBase),
		.regionBase(regionBase), .regionDescBytes(descBytes),
		.regionDescCount(descCount), .regionSizeValid(sizeValid),
		.regionStartIndex(startIdx), .regionCfgUpdate(cfgUpd)
	);

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic conclude();
		if (errCount == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input qprb_word_t seen, input qprb_word_t exp);
		samplesChecked++;
		if (seen !== exp) begin
			errCount++;
			$display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	// Holds the request until waitrequest is seen low, then releases it
	// and lets one edge pass so the next call never overlaps this one
	task automatic acc(input int a, input logic w, input qprb_word_t d,
		input logic [3:0] be, output qprb_word_t q);
		int n = 0;
		avs_address    <= qprb_addr_t'(a);
		avs_write      <= w;
		avs_read       <= !w;
		avs_writedata  <= d;
		avs_byteenable <= be;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		q = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			errCount++;
			conclude();
		end else begin
			@(posedge ref_clk);
		end
	endtask

	task automatic wr(input int a, input qprb_word_t d, input logic [3:0] be);
		qprb_word_t q;
		acc(a, 1'b1, d, be, q);
	endtask

	task automatic rdc(input int a, input qprb_word_t exp);
		qprb_word_t q;
		acc(a, 1'b0, 32'h0, 4'hf, q);
		chk(q, exp);
	endtask

	function automatic int ra(input int r, input int s);
		return 32'h100 + 32'h10 * r + 32'h4 * s;
	endfunction

	initial begin
		repeat (6) @(posedge ref_clk);
		rstn <= 1'b1;
		@(posedge ref_clk);
		// Upper write data must not leak into the 16-bit register
		wr(32'h0, 32'hffff1234, 4'hf);
		wr(32'h4, 32'h0000fedc, 4'hf);
		rdc(32'h0, 32'h1234);
		rdc(32'h4, 32'hfedc);
		chk(linkBase, 32'hfedc1234);
		wr(32'h4, 32'h0000aaaa, 4'h1);
		rdc(32'h4, 32'hfedc);
		// Every size code, reserved ones too, one per region
		for (int r = 0; r < 16; r++) begin
			wr(ra(r, 0), 32'hb000 + r, 4'hf);
			wr(ra(r, 1), 32'hc000 + r, 4'hf);
			wr(ra(r, 2), {16'hffff, 4'hf, 4'(r), 5'h1f, 3'(r)}, 4'hf);
			wr(ra(r, 3), 32'hffffffff - r, 4'hf);
		end
		for (int r = 0; r < 16; r++) begin
			rdc(ra(r, 0), 32'hb000 + r);
			rdc(ra(r, 1), 32'hc000 + r);
			rdc(ra(r, 2), {20'h0, 4'(r), 5'h0, 3'(r)});
			rdc(ra(r, 3), 32'h3fff - r);
			chk(regionBase[r], 32'hc000b000 + (r << 16) + r);
			chk(startIdx[r], 32'h3fff - r);
			chk(descBytes[r], r <= 8 ? 32'h20 << r : 32'h0);
			chk(sizeValid[r], r <= 8);
			chk(descCount[r], 32'h20 << (r % 8));
		end
		pendingIn <= {16'h5005, 16'h4004, 16'h3003, 16'h2002, 16'h1001,
			16'h8008};
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < 6; i++) begin
			rdc(32'h40 + 32'h4 * i, pendingIn[16 * i +: 16]);
		end
		wr(32'h40, 32'hffff, 4'hf);
		rdc(32'h40, 32'h8008);
		rdc(32'h58, 32'h0);
		// Status holds six pending rises plus the reserved size codes
		rdc(32'h8, 32'h7f);
		chk(irq, 1'b0);
		wr(32'hc, 32'h1, 4'hf);
		chk(irq, 1'b1);
		wr(32'h8, 32'h7f, 4'hf);
		chk(irq, 1'b0);
		rdc(32'h8, 32'h0);
		conclude();
	end
endmodule
